/* File: core/mbf_pkg.sv */
// Package for the microcontroller bus front end with paging
package mbf_pkg;
  // Array input and output sizes
  localparam int MBF_IN_W = 57;
  localparam int MBF_DEC_OUT = 15;
  localparam int MBF_DEC_PT = 39;
  localparam int MBF_GEN_OUT = 19;
  localparam int MBF_GEN_PT = 114;
  // Page register
  localparam int MBF_PAGE_W = 8;
  localparam logic [7:0] MBF_PAGE_RST = 8'h00;
  // Fast logic enable reset value
  localparam logic MBF_FAST_RST = 1'b1;
  // Input bus field positions
  localparam int MBF_IN_ADDR_LSB = 0;
  localparam int MBF_IN_PAGE_LSB = 16;
  localparam int MBF_IN_CTL0 = 24;
  localparam int MBF_IN_CTL1 = 25;
  localparam int MBF_IN_CTL2 = 26;
  localparam int MBF_IN_ALE = 27;
  localparam int MBF_IN_EXT_LSB = 28;
  localparam int MBF_IN_EXT_W = 29;
  // Decode output assigned to the page register itself
  localparam int MBF_CS_PAGE = 14;
  // Mode of control input zero
  typedef enum logic {MBF_C0_WR_N = 1'b0, MBF_C0_RW = 1'b1} mbf_c0_mode_t;
  // Mode of control input one
  typedef enum logic [1:0] {
    MBF_C1_RD_N = 2'b00, MBF_C1_ECLK = 2'b01, MBF_C1_DS_N = 2'b11, MBF_C1_PROGRAM_FETCH_STROBE_N_N = 2'b10
  } mbf_c1_mode_t;
  // Bus configuration bundle
  typedef struct packed {
    logic muxed;
    logic port_a_data;
    mbf_c0_mode_t c0_mode;
    mbf_c1_mode_t c1_mode;
    logic c2_is_fetch;
  } mbf_cfg_t;
  // Programmed array contents
  typedef struct packed {
    logic [MBF_DEC_PT-1:0][2*MBF_IN_W-1:0] dec_and;
    logic [MBF_DEC_OUT-1:0][MBF_DEC_PT-1:0] dec_or;
    logic [MBF_GEN_PT-1:0][2*MBF_IN_W-1:0] gen_and;
    logic [MBF_GEN_OUT-1:0][MBF_GEN_PT-1:0] gen_or;
  } mbf_prog_t;
endpackage : mbf_pkg

/* File: core/mbf_front_end.sv */
// Bus front end: latch, page register, decode and general arrays
`timescale 1ns/1ps
`default_nettype none
module mbf_front_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Configuration and programmed arrays
  input wire mbf_pkg::mbf_cfg_t cfg_i,
  input wire mbf_pkg::mbf_prog_t prog_i,
  // Power mode controls
  input wire logic fast_wr_i,
  input wire logic fast_val_i,
  input wire logic [mbf_pkg::MBF_IN_W-1:0] block_mask_i,
  // Pins from the microcontroller
  input wire logic [7:0] low_addr_data_port_i,
  input wire logic [7:0] high_addr_data_port_i,
  input wire logic [7:0] port_a_i,
  input wire logic address_strobe_in_i,
  input wire logic ctrl_input_zero_i,
  input wire logic ctrl_input_one_i,
  input wire logic ctrl_input_two_i,
  input wire logic [mbf_pkg::MBF_IN_EXT_W-1:0] ext_in_i,
  // Data drive back to the microcontroller
  output logic [7:0] low_addr_data_port_o,
  output logic low_addr_data_port_oe_o,
  output logic [7:0] port_a_o,
  output logic port_a_oe_o,
  // Read data from internal blocks
  input wire logic [7:0] blk_rdata_i,
  // Array results and state
  output logic [mbf_pkg::MBF_DEC_OUT-1:0] cs_o,
  output logic [mbf_pkg::MBF_GEN_OUT-1:0] gen_o,
  output logic [15:0] addr_o,
  output logic [7:0] page_o,
  output logic fast_o,
  output logic rd_o,
  output logic wr_o
);
  import mbf_pkg::*;

  // Two-stage synchronisers for pins
  logic [7:0] lo_s1, lo_s2, hi_s1, hi_s2, pa_s1, pa_s2;
  logic [3:0] ctl_s1, ctl_s2;
  logic [MBF_IN_EXT_W-1:0] ext_s1, ext_s2;
  always_ff @(posedge clk_i) begin
    lo_s1 <= low_addr_data_port_i;
    lo_s2 <= lo_s1;
    hi_s1 <= high_addr_data_port_i;
    hi_s2 <= hi_s1;
    pa_s1 <= port_a_i;
    pa_s2 <= pa_s1;
    ctl_s1 <= {address_strobe_in_i, ctrl_input_two_i, ctrl_input_one_i, ctrl_input_zero_i};
    ctl_s2 <= ctl_s1;
    ext_s1 <= ext_in_i;
    ext_s2 <= ext_s1;
  end

  // Named synchronised controls
  wire strobe = ctl_s2[3];
  wire c0 = ctl_s2[0];
  wire c1 = ctl_s2[1];
  wire c2 = ctl_s2[2];

  // Control zero decode
  wire wr_lvl = (cfg_i.c0_mode == MBF_C0_WR_N) ? !c0 : 1'b0;
  wire dir_rd = (cfg_i.c0_mode == MBF_C0_RW) ? c0 : 1'b1;
  wire dir_wr = (cfg_i.c0_mode == MBF_C0_RW) && !c0;
  // Control one and control two decode
  wire c1_act = (cfg_i.c1_mode == MBF_C1_ECLK) ? c1 : !c1;
  wire fetch_ok = cfg_i.c2_is_fetch ? !c2 : 1'b1;
  wire rd_lvl = c1_act && dir_rd && (cfg_i.c1_mode != MBF_C1_RD_N || cfg_i.c0_mode == MBF_C0_WR_N);
  wire wr_dir = c1_act && dir_wr && (cfg_i.c1_mode == MBF_C1_ECLK || cfg_i.c1_mode == MBF_C1_DS_N);
  wire wr_any = wr_lvl || wr_dir;
  logic wr_d;
  always_ff @(posedge clk_i) begin
    wr_d <= sys_rst_i ? 1'b0 : wr_any;
  end
  wire wr_end = wr_d && !wr_any;

  // Address latch, open while strobe high
  logic [15:0] addr;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr <= 16'h0000;
    end else if (strobe) begin
      addr <= {hi_s2, lo_s2};
    end
  end

  // Data in from low port or port A
  wire [7:0] wdata = (cfg_i.port_a_data && !cfg_i.muxed) ? pa_s2 : lo_s2;

  // Page register and fast bit
  logic [7:0] page;
  logic fast;
  logic [MBF_DEC_OUT-1:0] cs;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      page <= MBF_PAGE_RST;
    end else if (wr_end && cs[MBF_CS_PAGE]) begin
      page <= wdata;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fast <= MBF_FAST_RST;
    end else if (fast_wr_i) begin
      fast <= fast_val_i;
    end
  end

  // Array input bus with power-mode blocking
  logic [MBF_IN_W-1:0] raw_in;
  assign raw_in[MBF_IN_ADDR_LSB +: 16] = addr;
  assign raw_in[MBF_IN_PAGE_LSB +: 8] = page;
  assign raw_in[MBF_IN_CTL0] = c0;
  assign raw_in[MBF_IN_CTL1] = c1;
  assign raw_in[MBF_IN_CTL2] = c2;
  assign raw_in[MBF_IN_ALE] = strobe;
  assign raw_in[MBF_IN_EXT_LSB +: MBF_IN_EXT_W] = ext_s2;
  wire [MBF_IN_W-1:0] arr_in = raw_in & ~block_mask_i;
  wire [2*MBF_IN_W-1:0] lits = {~arr_in, arr_in};

  // Product terms: all selected literals true
  logic [MBF_DEC_PT-1:0] dec_pt;
  logic [MBF_GEN_PT-1:0] gen_pt;
  logic [MBF_DEC_OUT-1:0] dec_sum;
  logic [MBF_GEN_OUT-1:0] gen_sum;
  genvar g;
  generate
    for (g = 0; g < MBF_DEC_PT; g++) begin : g_dpt
      assign dec_pt[g] = &(lits | ~prog_i.dec_and[g]);
    end
    for (g = 0; g < MBF_DEC_OUT; g++) begin : g_dor
      assign dec_sum[g] = |(dec_pt & prog_i.dec_or[g]);
    end
    for (g = 0; g < MBF_GEN_PT; g++) begin : g_gpt
      assign gen_pt[g] = &(lits | ~prog_i.gen_and[g]);
    end
    for (g = 0; g < MBF_GEN_OUT; g++) begin : g_gor
      assign gen_sum[g] = |(gen_pt & prog_i.gen_or[g]);
    end
  endgenerate

  // Slow mode: evaluate only when inputs changed
  logic [MBF_IN_W-1:0] in_d;
  logic [MBF_GEN_OUT-1:0] gen;
  wire in_chg = (arr_in != in_d);
  always_ff @(posedge clk_i) begin
    in_d <= arr_in;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs <= '0;
      gen <= '0;
    end else if (fast || in_chg) begin
      cs <= dec_sum;
      gen <= gen_sum;
    end
  end

  // Read data mux: page register or block data
  wire sel_any = |cs;
  wire rd_go = rd_lvl && fetch_ok && sel_any;
  wire [7:0] rdata = cs[MBF_CS_PAGE] ? page : blk_rdata_i;
  logic [7:0] dout;
  logic drive;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dout <= 8'h00;
      drive <= 1'b0;
    end else begin
      dout <= rdata;
      drive <= rd_go;
    end
  end

  // Output drive
  assign low_addr_data_port_o = dout;
  assign port_a_o = dout;
  assign low_addr_data_port_oe_o = drive && !(cfg_i.port_a_data && !cfg_i.muxed);
  assign port_a_oe_o = drive && cfg_i.port_a_data && !cfg_i.muxed;
  assign cs_o = cs;
  assign gen_o = gen;
  assign addr_o = addr;
  assign page_o = page;
  assign fast_o = fast;
  assign rd_o = drive;
  assign wr_o = wr_d;
endmodule : mbf_front_end
`default_nettype wire

/* File: sim/mbf_checker.sv */
// Checker for the bus front end ports
`timescale 1ns/1ps
`default_nettype none
module mbf_checker (
  // Watched ports
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire mbf_pkg::mbf_cfg_t cfg_i,
  input wire logic fast_wr_i,
  input wire logic fast_val_i,
  input wire logic [7:0] low_addr_data_port_i,
  input wire logic [7:0] high_addr_data_port_i,
  input wire logic address_strobe_in_i,
  input wire logic low_addr_data_port_oe_o,
  input wire logic port_a_oe_o,
  input wire logic [14:0] cs_o,
  input wire logic [18:0] gen_o,
  input wire logic [15:0] addr_o,
  input wire logic [7:0] page_o,
  input wire logic fast_o,
  input wire logic wr_o
);
  import mbf_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Output relations
  chk_reset_vals:
  assert property ($fell(sys_rst_i) |-> addr_o == 16'h0000 && page_o == 8'h00 && fast_o && cs_o == 15'h0000
    && gen_o == 19'h00000 && !low_addr_data_port_oe_o) else $error("reset values wrong");
  chk_addr_latch:
  assert property ((address_strobe_in_i && $stable(low_addr_data_port_i) && $stable(high_addr_data_port_i)) [*4]
    |-> addr_o == {high_addr_data_port_i, low_addr_data_port_i}) else $error("address not latched");
  chk_addr_hold:
  assert property (!address_strobe_in_i [*5] |-> $stable(addr_o)) else $error("address moved");
  chk_drive_sel:
  assert property (low_addr_data_port_oe_o |-> $past(|cs_o) || |cs_o) else $error("drive without select");
  chk_port_a:
  assert property (port_a_oe_o |-> cfg_i.port_a_data) else $error("port a driven");
  chk_fast_load:
  assert property (fast_wr_i |=> fast_o == $past(fast_val_i)) else $error("fast bit not loaded");
  chk_fast_hold:
  assert property (!fast_wr_i |=> $stable(fast_o)) else $error("fast bit moved");
  chk_page_write:
  assert property ($changed(page_o) |-> $past(wr_o) || $past(wr_o, 2)) else $error("page moved");
  // Main scenarios
  cov_read: cover property (low_addr_data_port_oe_o);
  cov_page: cover property ($changed(page_o));
  cov_slow: cover property (!fast_o);
endmodule : mbf_checker
bind mbf_front_end mbf_checker i_chk (.*);
`default_nettype wire

/* File: sim/mbf_host_model.sv */
// Multiplexed bus microcontroller model
`timescale 1ns/1ps
`default_nettype none
module mbf_host_model (
  // Clock and pins
  input wire logic clk_i,
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o = 8'h00,
  output logic [7:0] a_hi_o = 8'h00,
  output logic strobe_o = 1'b0,
  output logic wr_n_o = 1'b1,
  output logic rd_n_o = 1'b1
);
  // Latch address, then read or write strobe
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    {a_hi_o, ad_o} <= a;
    strobe_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    strobe_o <= 1'b0;
    @(posedge clk_i);
    ad_o <= wr ? d : ~a[7:0]; // Released lines show the inverse
    wr_n_o <= !wr;
    rd_n_o <= wr;
    repeat (6) @(posedge clk_i);
    q = ad_i;
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : access
endmodule : mbf_host_model
`default_nettype wire

/* File: sim/tb_mbf_front_end.sv */
// Testbench for the bus front end
`timescale 1ns/1ps
`default_nettype none
module tb_mbf_front_end;
  import mbf_pkg::*;
  localparam mbf_cfg_t CFG = '{1'b1, 1'b0, MBF_C0_WR_N, MBF_C1_RD_N, 1'b0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  mbf_cfg_t cfg = CFG;
  logic fast_wr = 1'b0;
  logic fast_val = 1'b0;
  logic [56:0] mask = '0;
  logic [28:0] ext = '0;
  logic [7:0] pv [2] = '{8'hff, 8'h01};
  mbf_prog_t prog;
  logic [7:0] ad_host, hi, ad_dut, q, page;
  logic ad_oe, strobe, wr_n, rd_n, fast;
  logic [14:0] cs;
  logic [18:0] gen;
  logic [15:0] addr;
  int bad_count = 0;
  int checks_done = 0;
  // Resolved low port
  wire logic [7:0] ad_pin = ad_oe ? ad_dut : ad_host;
  mbf_front_end i_dut (.clk_i(clk), .sys_rst_i(rst), .cfg_i(cfg), .prog_i(prog), .fast_wr_i(fast_wr),
    .fast_val_i(fast_val), .block_mask_i(mask), .low_addr_data_port_i(ad_pin), .high_addr_data_port_i(hi),
    .port_a_i(8'h00), .address_strobe_in_i(strobe), .ctrl_input_zero_i(wr_n), .ctrl_input_one_i(rd_n),
    .ctrl_input_two_i(1'b1), .ext_in_i(ext), .low_addr_data_port_o(ad_dut), .low_addr_data_port_oe_o(ad_oe),
    .port_a_o(), .port_a_oe_o(), .blk_rdata_i(8'h5a), .cs_o(cs), .gen_o(gen), .addr_o(addr), .page_o(page),
    .fast_o(fast), .rd_o(), .wr_o());
  mbf_host_model i_host (.clk_i(clk), .ad_i(ad_pin), .ad_o(ad_host), .a_hi_o(hi), .strobe_o(strobe),
    .wr_n_o(wr_n), .rd_n_o(rd_n));
  // Comparison with count
  task automatic cmp(input string what, input logic [18:0] exp, input logic [18:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial forever #2.5 clk = ~clk;
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
  // Tests
  initial begin
    prog = '0;
    prog.dec_and[0][15] = 1'b1;
    prog.dec_or[0][0] = 1'b1;
    prog.dec_and[1][16] = 1'b1;
    prog.dec_or[1][1] = 1'b1;
    prog.dec_and[2][72] = 1'b1;
    prog.dec_and[2][14] = 1'b1;
    prog.dec_or[14][2] = 1'b1;
    prog.gen_and[0][28] = 1'b1;
    prog.gen_or[0][0] = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp("page", 8'h00, page);
    cmp("fast", 1'b1, fast);
    $display("reset test done");
    i_host.access(1'b0, 16'h8123, 8'h00, q);
    cmp("addr", 16'h8123, addr);
    cmp("cs", 15'h0001, cs);
    cmp("rdata", 8'h5a, q);
    i_host.access(1'b0, 16'h0100, 8'h00, q);
    cmp("cs", 15'h0000, cs);
    cmp("refused", 8'hff, q);
    $display("read test done");
    foreach (pv[i]) begin
      i_host.access(1'b1, 16'h4000, pv[i], q);
      cmp("page", pv[i], page);
    end
    i_host.access(1'b0, 16'h0100, 8'h00, q);
    cmp("cs", 15'h0002, cs);
    cmp("rdata", 8'h5a, q);
    $display("page test done");
    cfg.c2_is_fetch <= 1'b1;
    i_host.access(1'b0, 16'h0100, 8'h00, q);
    cmp("fetch", 8'hff, q);
    cfg.c2_is_fetch <= 1'b0;
    $display("fetch test done");
    fast_wr <= 1'b1;
    @(posedge clk);
    fast_wr <= 1'b0;
    @(posedge clk);
    cmp("fast", 1'b0, fast);
    ext <= 29'h00000001;
    repeat (5) @(posedge clk);
    cmp("gen", 19'h00001, gen);
    mask[28] <= 1'b1;
    repeat (5) @(posedge clk);
    cmp("gen", 19'h00000, gen);
    $display("slow test done");
    tally_and_finish();
  end
endmodule : tb_mbf_front_end
`default_nettype wire
